// ===== design/xtal_freq_watchdog.sv
`timescale 1ns/10ps
`default_nettype none

module xtal_freq_watchdog
    import xtal_det_pkg::*;
#(
    parameter int DETECT_CYCLES = DETECT_CYC,
    parameter int EDGE_LIMIT = EDGE_THRESH,
    parameter int WDOG_CYCLES = WDOG_CYC
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // crystal oscillator, sampled
    input wire logic I_XTAL,
    // receiver: first correct telegram, pulse
    input wire logic I_TELEGRAM_OK,
    // clock generator control
    output logic O_SEL_16M,
    output logic O_LOCKED,
    output logic O_DET_ACTIVE,
    // unconditional device reset, active high level
    output logic O_WDOG_RST
);

    typedef struct packed {
        det_state_e st;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] edge_cnt;
        logic xtal_prev;
        clk_ctrl_s out;
    } det_s;

    det_s r;
    det_s next_r;
    logic xtal_edge;
    logic wd_timeout;

    // ==========================================================
    // oscillation edges
    assign xtal_edge = I_XTAL & ~r.xtal_prev;

    osc_loss_timer #(
        .LIMIT(WDOG_CYCLES)
    ) u_loss (
        .clk(I_CLK),
        .rst_b(I_RST_B),
        .i_edge(xtal_edge),
        .o_timeout(wd_timeout)
    );

    // ==========================================================
    // detection and lock
    always_comb begin
        next_r = r;
        next_r.xtal_prev = I_XTAL;
        next_r.out.wdog_rst = wd_timeout;
        if (wd_timeout) begin
            // RULE6: back to power-on defaults
            next_r.st = ST_DETECT;
            next_r.win_cnt = '0;
            next_r.edge_cnt = '0;
            next_r.out.sel_16m = SEL_16M_RESET;
        end else begin
            case (r.st)
                ST_DETECT: begin
                    next_r.win_cnt = r.win_cnt + CNT_W'(1);
                    if (xtal_edge) begin
                        next_r.edge_cnt = r.edge_cnt + CNT_W'(1);
                    end
                    // RULE2: decide at window end
                    if (r.win_cnt == CNT_W'(DETECT_CYCLES - 1)) begin
                        // RULE3: window restarts, choice may change
                        next_r.out.sel_16m =
                            (r.edge_cnt >= CNT_W'(EDGE_LIMIT));
                        next_r.win_cnt = '0;
                        next_r.edge_cnt = '0;
                    end
                    // RULE4: good telegram freezes choice
                    if (I_TELEGRAM_OK) begin
                        next_r.st = ST_LOCKED;
                        next_r.out.sel_16m = r.out.sel_16m;
                        next_r.win_cnt = '0;
                        next_r.edge_cnt = '0;
                    end
                end
                ST_LOCKED: begin
                    // bursts are ignored here by design
                end
                default: begin
                    next_r.st = ST_DETECT;
                end
            endcase
        end
        next_r.out.locked = (next_r.st == ST_LOCKED);
        next_r.out.det_active = (next_r.st == ST_DETECT);
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            // RULE1: 16 MHz default
            r <= '{st: ST_DETECT, win_cnt: '0, edge_cnt: '0,
                   xtal_prev: 1'h0,
                   out: '{sel_16m: SEL_16M_RESET, locked: 1'h0,
                          det_active: 1'h1, wdog_rst: 1'h0}};
        end else begin
            r <= next_r;
        end
    end

    assign O_SEL_16M = r.out.sel_16m;
    assign O_LOCKED = r.out.locked;
    assign O_DET_ACTIVE = r.out.det_active;
    assign O_WDOG_RST = r.out.wdog_rst;

endmodule // xtal_freq_watchdog

`default_nettype wire

// ===== design/xtal_det_pkg.sv
// Contract
// RULE1: after power-on, start in 16 MHz setting
// RULE2: after about 200 us, pick 5.333 or 16
// RULE3: keep re-detecting until first good telegram
// RULE4: lock selection after first good telegram
// RULE5: force device reset when clock stops 20 us
// RULE6: watchdog reset clears lock, restarts detection
`default_nettype none
package xtal_det_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int T_DETECT_US = 200;
    localparam int T_WDOG_US = 20;
    localparam int DETECT_CYC = T_DETECT_US * CLK_MHZ;
    // shortest stop that resets is one idle cycle longer than this count
    localparam int WDOG_CYC = T_WDOG_US * CLK_MHZ;

    // ==========================================================
    // crystal rates and edge decision
    localparam int XTAL_HI_KHZ = 16000;
    localparam int XTAL_LO_KHZ = 5333;
    localparam int EDGES_HI = XTAL_HI_KHZ * T_DETECT_US / 1000;
    localparam int EDGES_LO = XTAL_LO_KHZ * T_DETECT_US / 1000;
    localparam int EDGE_THRESH = (EDGES_HI + EDGES_LO) / 2;

    // ==========================================================
    // widths and reset values
    localparam int CNT_W = 16;
    localparam logic SEL_16M_RESET = 1'h1;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ST_DETECT = 2'h1,
        ST_LOCKED = 2'h2
    } det_state_e;

    typedef struct packed {
        logic sel_16m;
        logic locked;
        logic det_active;
        logic wdog_rst;
    } clk_ctrl_s;

endpackage : xtal_det_pkg
`default_nettype wire

// ===== design/osc_loss_timer.sv
`timescale 1ns/10ps
`default_nettype none

module osc_loss_timer
    import xtal_det_pkg::*;
#(
    parameter int LIMIT = WDOG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // oscillation activity
    input wire logic i_edge,
    // loss indication, level
    output logic o_timeout
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic timeout;
    } tmr_s;

    tmr_s r;
    tmr_s next_r;

    // ==========================================================
    // idle counter
    always_comb begin
        next_r = r;
        // RULE5: count idle cycles
        if (i_edge) begin
            next_r.cnt = '0;
            next_r.timeout = 1'h0;
        end else if (r.cnt >= CNT_W'(LIMIT)) begin
            // saturate: reset held until oscillation returns
            next_r.timeout = 1'h1;
        end else begin
            next_r.cnt = r.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_timeout = r.timeout;

endmodule // osc_loss_timer

`default_nettype wire

// ===== verification/xtal_freq_watchdog_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// clock control checks
module xtal_watch_chk #(
    parameter int WDOG_CYCLES = 50
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_XTAL,
    input wire logic I_TELEGRAM_OK,
    input wire logic O_SEL_16M,
    input wire logic O_LOCKED,
    input wire logic O_DET_ACTIVE,
    input wire logic O_WDOG_RST
);
    logic last;
    int idle;
    // idle cycles since last rising crystal edge
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            last <= 1'b0;
            idle <= 0;
        end else begin
            last <= I_XTAL;
            idle <= (I_XTAL && !last) ? 0 : idle + 1;
        end
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    start_default_a: assert property (
        $rose(I_RST_B) |-> O_SEL_16M [*8]) else $error("no default");
    det_lock_a: assert property (
        O_DET_ACTIVE != O_LOCKED) else $error("active vs lock");
    lock_take_a: assert property (
        I_TELEGRAM_OK && O_DET_ACTIVE && !O_WDOG_RST && idle < WDOG_CYCLES
        |=> O_LOCKED) else $error("no lock");
    sel_held_a: assert property (
        O_LOCKED ##1 O_LOCKED |-> $stable(O_SEL_16M)) else $error("moved");
    wdog_fire_a: assert property (
        idle > WDOG_CYCLES + 5 |-> O_WDOG_RST) else $error("no wdog");
    wdog_early_a: assert property (
        $rose(O_WDOG_RST) |-> idle >= WDOG_CYCLES) else $error("early");
    wdog_clear_a: assert property (
        O_WDOG_RST |-> O_SEL_16M && !O_LOCKED) else $error("not cleared");
endmodule // xtal_watch_chk
bind xtal_freq_watchdog xtal_watch_chk #(.WDOG_CYCLES(WDOG_CYCLES)) i_chk (
    .I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_XTAL(I_XTAL),
    .I_TELEGRAM_OK(I_TELEGRAM_OK), .O_SEL_16M(O_SEL_16M),
    .O_LOCKED(O_LOCKED), .O_DET_ACTIVE(O_DET_ACTIVE),
    .O_WDOG_RST(O_WDOG_RST));
`default_nettype wire

// ===== verification/xtal_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// crystal: stands still when stopped
module xtal_osc_model (
    input wire logic clk,
    input wire logic run,
    input var int half,
    output logic xtal
);
    int cnt = 0;
    initial xtal = 1'b0;
    always @(negedge clk) begin
        if (run) begin
            cnt++;
            if (cnt >= half) begin
                cnt = 0;
                xtal <= ~xtal;
            end
        end
    end
endmodule // xtal_osc_model
`default_nettype wire

// ===== verification/xtal_freq_watchdog_tb.sv
`timescale 1ns/10ps
`default_nettype none
module xtal_freq_watchdog_tb;
    localparam int WIN = 200, LIM = 21, WD = 50;
    logic I_CLK = 0, I_RST_B = 0, I_TELEGRAM_OK = 0, run = 0, hi, keep;
    logic I_XTAL, sel, lck, act, wd;
    int half = 2, fail_count = 0, n_checks = 0, cyc = 0, seed = 32'h9B0A19B8;
    initial forever #5 I_CLK = ~I_CLK;
    xtal_osc_model i_osc (.clk(I_CLK), .run(run), .half(half), .xtal(I_XTAL));
    xtal_freq_watchdog #(.DETECT_CYCLES(WIN), .EDGE_LIMIT(LIM),
        .WDOG_CYCLES(WD)) i_dut (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
        .I_XTAL(I_XTAL), .I_TELEGRAM_OK(I_TELEGRAM_OK), .O_SEL_16M(sel),
        .O_LOCKED(lck), .O_DET_ACTIVE(act), .O_WDOG_RST(wd));
    task finish_test;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge I_CLK) if (++cyc > 20000) begin
        fail_count++;
        finish_test();
    end
    task chk(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // edges per window decide the setting
    function automatic logic model(input int h);
        return (WIN / (2 * h)) >= LIM;
    endfunction
    task wt(input int n);
        repeat (n) @(negedge I_CLK);
    endtask
    task pick(input logic h);
        half = h ? 2 + {$random(seed)} % 2 : 8 + {$random(seed)} % 8;
    endtask
    initial begin
        for (int t = 0; t < 4; t++) begin
            hi = t[0];
            I_RST_B = 0;
            run = 0;
            pick(hi);
            wt(20);
            I_RST_B = 1;
            run = 1;
            chk(sel, 1'b1, "default");
            wt(WIN + 30);
            chk(sel, model(half), "first pick");
            pick(!hi);
            wt(2 * WIN + 30);
            chk(sel, model(half), "redetect");
            I_TELEGRAM_OK = 1;
            wt(1);
            I_TELEGRAM_OK = 0;
            chk(lck, 1'b1, "lock");
            chk(act, 1'b0, "detect off");
            keep = sel;
            pick(hi);
            wt(2 * WIN + 30);
            chk(sel, keep, "held");
            run = 0;
            wt(WD + 10);
            chk(wd, 1'b1, "wdog");
            chk(lck, 1'b0, "unlock");
            chk(act, 1'b1, "detect on");
            run = 1;
            wt(WIN + 60);
            chk(wd, 1'b0, "wdog off");
            chk(sel, model(half), "restart");
        end
        finish_test();
    end
endmodule // xtal_freq_watchdog_tb
`default_nettype wire
